// ### bst_consts.svh
// Purpose: shared constants of the boundary-scan test port
// Assumes: included by bare name from every file that uses its macros
// Notes: instruction encodings and identity fields are local choices
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH
`define BST_IR_LEN 10
`define BST_IR_CAPT 10'h001
`define BST_I_EXTEST 10'h000
`define BST_I_CFG_LOAD 10'h002
`define BST_I_SAMPLE 10'h005
`define BST_I_IDCODE 10'h006
`define BST_I_USERCODE 10'h007
`define BST_I_CLAMP 10'h00a
`define BST_I_HIGHZ 10'h00b
`define BST_I_ANALYZER 10'h00e
`define BST_I_BYPASS 10'h3ff
`define BST_DR_MAX 32
`define BST_USER_LEN 32
`define BST_ID_LEN 32
`define BST_BSR_LEN 1524
`define BST_CFG_LEN 8
`define BST_PROBE_LEN 32
// identity fields: arbitrary values
`define BST_ID_VERSION 4'h1
`define BST_ID_PART 16'h0abc
`define BST_ID_MAKER 11'h055
`endif

// ### bst_pkg.sv
// Purpose: types of the boundary-scan test port
// Assumes: nothing
// Notes: used with explicit scope, never imported
package bst_pkg;
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} bst_tap_state_type;
	typedef enum logic [1:0] {PM_NORMAL, PM_DRIVE, PM_CLAMP, PM_HIGHZ} bst_pin_mode_type;
endpackage

// ### bst_dr_if.sv
// Purpose: control strobes between the tap controller and the boundary register
// Assumes: all signals in the tck domain
// Notes: strobes are levels decoded from the tap state
`timescale 1ns/1ps
`default_nettype none
interface bst_dr_if;
	logic capture;
	logic shift;
	logic update;
	logic tdi;
	logic sdo;
	modport tap (output capture, output shift, output update, output tdi, input sdo);
	modport chain (input capture, input shift, input update, input tdi, output sdo);
endinterface
`default_nettype wire

// ### bst_shift_reg.sv
// Purpose: capture, shift and update register for one scan chain
// Assumes: clocked by tck; reset already synchronised
// Notes: shifts lsb first, tdi enters the msb
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"
module bst_shift_reg #(
	parameter int WIDTH = `BST_BSR_LEN
) (
	// clock and reset
	input wire logic tck_in,
	input wire logic rst_n_in,
	// strobes
	bst_dr_if.chain dr,
	// parallel sides
	input wire logic [WIDTH-1:0] cap_in,
	output logic [WIDTH-1:0] upd_out
);
	typedef struct packed {
		logic [WIDTH-1:0] sh;
		logic [WIDTH-1:0] upd;
	} bst_chain_type;
	bst_chain_type s_reg;
	bst_chain_type s_next;

	// capture wins over shift, update copies the shifted pattern
	always_comb
	begin
		s_next = s_reg;
		if (dr.capture)
			s_next.sh = cap_in;
		else if (dr.shift)
			s_next.sh = {dr.tdi, s_reg.sh[WIDTH-1:1]};
		if (dr.update)
			s_next.upd = s_reg.sh;
	end

	// state register
	always_ff @(posedge tck_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign dr.sdo = s_reg.sh[0];
	assign upd_out = s_reg.upd;
endmodule // bst_shift_reg
`default_nettype wire

// ### bst_tap_top.sv
// Purpose: test access port with instruction, bypass, id, user, config and boundary registers
// Assumes: tck is a free clock of its own; pins, core and busy signals cross by two flip-flops
// Notes: pin outputs are produced in the system clock domain from a word handed over by toggle
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"
// Notes on behaviour
// - tap state machine, instruction and data registers follow the 1990 boundary-scan standard
// - boundary tests only before or after configuration, never while it runs
// - instruction register is exactly 10 bits long
// - sample/preload captures pins and preloads a pattern without disturbing operation
// - extest drives outputs from the boundary register and captures inputs
// - bypass puts a single one-bit stage between tdi and tdo
// - highz uses bypass and floats every user pin
// - clamp uses bypass and holds pins at the boundary register levels
// - bus hold or pull-up beats the high-impedance state of test modes
// - usercode shifts out a 32-bit user code
// - idcode shifts version, part number, maker code and a fixed bit
// - lowest identification bit is always one
// - boundary register length depends on device size, 1524 up to 3228
// - config-load instructions let a controller load configuration serially
// - analyzer instructions observe internal signals; sample path is shared with it; here analyzer captures probe_in in the 32-bit data register instead
module bst_tap_top #(
	parameter int BSR_LEN = `BST_BSR_LEN,
	parameter int PROBE_LEN = `BST_PROBE_LEN
) (
	// system clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// test port
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic tdo_oe_n_out,
	// device status and identity
	input wire logic config_busy_in,
	input wire logic [`BST_USER_LEN-1:0] usercode_in,
	input wire logic [PROBE_LEN-1:0] probe_in,
	// core side of the user pins
	input wire logic [BSR_LEN/3-1:0] core_out_in,
	input wire logic [BSR_LEN/3-1:0] core_oe_n_in,
	input wire logic [BSR_LEN/3-1:0] pin_keep_in,
	// pad side of the user pins
	input wire logic [BSR_LEN/3-1:0] pin_in,
	output logic [BSR_LEN/3-1:0] pin_out,
	output logic [BSR_LEN/3-1:0] pin_oe_n_out,
	output logic [BSR_LEN/3-1:0] pin_hold_out,
	// configuration bytes toward the configuration engine
	output logic [`BST_CFG_LEN-1:0] cfg_data_out,
	output logic cfg_valid_out
);
	localparam int NP = BSR_LEN / 3;
	localparam int DRW = `BST_DR_MAX;

	// tck domain, rising edge
	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic busy_meta;
		logic busy_sync;
		logic [NP-1:0] pin_meta;
		logic [NP-1:0] pin_sync;
		logic [NP-1:0] core_meta;
		logic [NP-1:0] core_sync;
		logic [NP-1:0] coe_meta;
		logic [NP-1:0] coe_sync;
		logic [`BST_USER_LEN-1:0] user_meta;
		logic [`BST_USER_LEN-1:0] user_sync;
		logic [PROBE_LEN-1:0] probe_meta;
		logic [PROBE_LEN-1:0] probe_sync;
		bst_pkg::bst_tap_state_type state;
		logic [`BST_IR_LEN-1:0] ir_sh;
		logic [`BST_IR_LEN-1:0] ir;
		logic [DRW-1:0] dr_sh;
		bst_pkg::bst_pin_mode_type mode;
		logic mode_tgl;
		logic [`BST_CFG_LEN-1:0] cfg_byte;
		logic cfg_tgl;
	} bst_tck_type;

	// tck domain, falling edge
	typedef struct packed {
		logic tdo;
		logic tdo_oe_n;
	} bst_neg_type;

	// system clock domain
	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic [2:0] mode_tgl;
		logic [2:0] cfg_tgl;
		bst_pkg::bst_pin_mode_type mode;
		logic [BSR_LEN-1:0] upd;
		logic [`BST_CFG_LEN-1:0] cfg_data;
		logic cfg_valid;
		logic [NP-1:0] pin;
		logic [NP-1:0] pin_oe_n;
		logic [NP-1:0] hold;
	} bst_sys_type;

	bst_tck_type t_reg;
	bst_tck_type t_next;
	bst_neg_type n_reg;
	bst_neg_type n_next;
	bst_sys_type s_reg;
	bst_sys_type s_next;
	logic [BSR_LEN-1:0] bsr_cap;
	logic [BSR_LEN-1:0] bsr_upd;
	logic sel_bsr;
	logic bsr_instr;
	logic [5:0] dr_len;
	logic [DRW-1:0] dr_cap;

	bst_dr_if bsr_if ();

	// boundary chain: per pin an input cell, an output cell and an enable cell
	bst_shift_reg #(
		.WIDTH(BSR_LEN)
	) u_bsr (
		.tck_in(tck_in),
		.rst_n_in(t_reg.rst_sync),
		.dr(bsr_if.chain),
		.cap_in(bsr_cap),
		.upd_out(bsr_upd)
	);

	// boundary capture vector from the synchronised pins and core signals
	always_comb
	begin
		bsr_cap = '0;
		for (int i = 0; i < NP; i++)
		begin
			bsr_cap[3*i] = t_reg.pin_sync[i];
			bsr_cap[3*i+1] = t_reg.core_sync[i];
			bsr_cap[3*i+2] = t_reg.coe_sync[i];
		end
	end

	// data register selection; boundary instructions fall back to bypass during configuration
	always_comb
	begin
		bsr_instr = (t_reg.ir == `BST_I_EXTEST) || (t_reg.ir == `BST_I_SAMPLE);
		sel_bsr = bsr_instr && !t_reg.busy_sync;
		dr_len = 6'h01;
		dr_cap = '0;
		case (t_reg.ir)
			`BST_I_IDCODE:
			begin
				dr_len = 6'h20;
				dr_cap = {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1};
			end
			`BST_I_USERCODE:
			begin
				dr_len = 6'h20;
				dr_cap = t_reg.user_sync;
			end
			`BST_I_ANALYZER:
			begin
				dr_len = 6'h20;
				dr_cap = DRW'(t_reg.probe_sync);
			end
			`BST_I_CFG_LOAD:
			begin
				dr_len = 6'h08;
			end
			default:
			begin
				dr_len = 6'h01;
			end
		endcase
	end

	// strobes to the boundary chain
	assign bsr_if.capture = sel_bsr && (t_reg.state == bst_pkg::CAP_DR);
	assign bsr_if.shift = sel_bsr && (t_reg.state == bst_pkg::SH_DR);
	assign bsr_if.update = sel_bsr && (t_reg.state == bst_pkg::UPD_DR);
	assign bsr_if.tdi = tdi_in;

	// tck rising edge: synchronisers, tap walk, instruction and data shifting
	always_comb
	begin
		t_next = t_reg;
		t_next.rst_meta = 1'b1;
		t_next.rst_sync = t_reg.rst_meta;
		t_next.busy_meta = config_busy_in;
		t_next.busy_sync = t_reg.busy_meta;
		t_next.pin_meta = pin_in;
		t_next.pin_sync = t_reg.pin_meta;
		t_next.core_meta = core_out_in;
		t_next.core_sync = t_reg.core_meta;
		t_next.coe_meta = core_oe_n_in;
		t_next.coe_sync = t_reg.coe_meta;
		t_next.user_meta = usercode_in;
		t_next.user_sync = t_reg.user_meta;
		t_next.probe_meta = probe_in;
		t_next.probe_sync = t_reg.probe_meta;
		// tap state machine
		case (t_reg.state)
			bst_pkg::TLR: t_next.state = tms_in ? bst_pkg::TLR : bst_pkg::RTI;
			bst_pkg::RTI: t_next.state = tms_in ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_DR: t_next.state = tms_in ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
			bst_pkg::CAP_DR: t_next.state = tms_in ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			bst_pkg::SH_DR: t_next.state = tms_in ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			bst_pkg::EX1_DR: t_next.state = tms_in ? bst_pkg::UPD_DR : bst_pkg::PAU_DR;
			bst_pkg::PAU_DR: t_next.state = tms_in ? bst_pkg::EX2_DR : bst_pkg::PAU_DR;
			bst_pkg::EX2_DR: t_next.state = tms_in ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
			bst_pkg::UPD_DR: t_next.state = tms_in ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_IR: t_next.state = tms_in ? bst_pkg::TLR : bst_pkg::CAP_IR;
			bst_pkg::CAP_IR: t_next.state = tms_in ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
			bst_pkg::SH_IR: t_next.state = tms_in ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
			bst_pkg::EX1_IR: t_next.state = tms_in ? bst_pkg::UPD_IR : bst_pkg::PAU_IR;
			bst_pkg::PAU_IR: t_next.state = tms_in ? bst_pkg::EX2_IR : bst_pkg::PAU_IR;
			bst_pkg::EX2_IR: t_next.state = tms_in ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
			bst_pkg::UPD_IR: t_next.state = tms_in ? bst_pkg::SEL_DR : bst_pkg::RTI;
			default: t_next.state = bst_pkg::TLR;
		endcase
		case (t_reg.state)
			bst_pkg::TLR:
			begin
				t_next.ir = `BST_I_IDCODE;
				if (t_reg.mode != bst_pkg::PM_NORMAL)
				begin
					t_next.mode = bst_pkg::PM_NORMAL;
					t_next.mode_tgl = !t_reg.mode_tgl;
				end
			end
			bst_pkg::CAP_IR: t_next.ir_sh = `BST_IR_CAPT;
			bst_pkg::SH_IR: t_next.ir_sh = {tdi_in, t_reg.ir_sh[`BST_IR_LEN-1:1]};
			bst_pkg::UPD_IR:
			begin
				t_next.ir = t_reg.ir_sh;
				// test mode chosen when the instruction takes effect; refused while configuring
				if (t_reg.busy_sync)
					t_next.mode = bst_pkg::PM_NORMAL;
				else if (t_reg.ir_sh == `BST_I_EXTEST)
					t_next.mode = bst_pkg::PM_DRIVE;
				else if (t_reg.ir_sh == `BST_I_CLAMP)
					t_next.mode = bst_pkg::PM_CLAMP;
				else if (t_reg.ir_sh == `BST_I_HIGHZ)
					t_next.mode = bst_pkg::PM_HIGHZ;
				else
					t_next.mode = bst_pkg::PM_NORMAL;
				t_next.mode_tgl = !t_reg.mode_tgl;
			end
			bst_pkg::CAP_DR: t_next.dr_sh = dr_cap;
			bst_pkg::SH_DR:
			begin
				// lsb leaves first, tdi enters at the top of the selected length
				for (int i = 0; i < DRW; i++)
					t_next.dr_sh[i] = (i == int'(dr_len) - 1) ? tdi_in :
						((i < int'(dr_len) - 1) ? t_reg.dr_sh[(i + 1) % DRW] : 1'b0);
			end
			bst_pkg::UPD_DR:
			begin
				if (t_reg.ir == `BST_I_CFG_LOAD)
				begin
					t_next.cfg_byte = t_reg.dr_sh[`BST_CFG_LEN-1:0];
					t_next.cfg_tgl = !t_reg.cfg_tgl;
				end
				else if (sel_bsr)
					t_next.mode_tgl = !t_reg.mode_tgl; // new pattern for extest/sample
			end
			default:
			begin
				t_next.ir = t_reg.ir;
			end
		endcase
		if (!t_reg.rst_sync)
		begin
			t_next.state = bst_pkg::TLR;
			t_next.ir = `BST_I_IDCODE;
			t_next.mode = bst_pkg::PM_NORMAL;
		end
	end

	always_ff @(posedge tck_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			t_reg <= '{state: bst_pkg::TLR, ir: `BST_I_IDCODE, mode: bst_pkg::PM_NORMAL, default: '0};
		else
			t_reg <= t_next;
	end

	// tdo: launched on the falling edge, driven only in shift states
	always_comb
	begin
		n_next.tdo = 1'b0;
		n_next.tdo_oe_n = 1'b1;
		if (t_reg.state == bst_pkg::SH_IR)
		begin
			n_next.tdo = t_reg.ir_sh[0];
			n_next.tdo_oe_n = 1'b0;
		end
		else if (t_reg.state == bst_pkg::SH_DR)
		begin
			n_next.tdo = sel_bsr ? bsr_if.sdo : t_reg.dr_sh[0];
			n_next.tdo_oe_n = 1'b0;
		end
		if (!t_reg.rst_sync)
			n_next.tdo_oe_n = 1'b1;
	end

	always_ff @(negedge tck_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			n_reg <= '{tdo: 1'b0, tdo_oe_n: 1'b1};
		else
			n_reg <= n_next;
	end

	// system side: takes the mode word and pattern when the toggle arrives, muxes the pads
	// the tck side holds the word for several tck periods, far longer than the three-flop catch
	always_comb
	begin
		s_next = s_reg;
		s_next.rst_meta = 1'b1;
		s_next.rst_sync = s_reg.rst_meta;
		s_next.mode_tgl = {s_reg.mode_tgl[1:0], t_reg.mode_tgl};
		s_next.cfg_tgl = {s_reg.cfg_tgl[1:0], t_reg.cfg_tgl};
		s_next.cfg_valid = 1'b0;
		if (s_reg.mode_tgl[2] != s_reg.mode_tgl[1])
		begin
			s_next.mode = t_reg.mode;
			s_next.upd = bsr_upd;
		end
		if (s_reg.cfg_tgl[2] != s_reg.cfg_tgl[1])
		begin
			s_next.cfg_data = t_reg.cfg_byte;
			s_next.cfg_valid = 1'b1;
		end
		for (int i = 0; i < NP; i++)
		begin
			s_next.pin[i] = core_out_in[i];
			s_next.pin_oe_n[i] = core_oe_n_in[i];
			s_next.hold[i] = 1'b0;
			// configuration in progress overrides any test mode
			if (!config_busy_in)
			begin
				case (s_reg.mode)
					bst_pkg::PM_DRIVE, bst_pkg::PM_CLAMP:
					begin
						s_next.pin[i] = s_reg.upd[3*i+1];
						s_next.pin_oe_n[i] = s_reg.upd[3*i+2];
					end
					bst_pkg::PM_HIGHZ:
					begin
						s_next.pin_oe_n[i] = 1'b1;
					end
					default:
					begin
						s_next.pin_oe_n[i] = core_oe_n_in[i];
					end
				endcase
				if (s_reg.mode != bst_pkg::PM_NORMAL)
					s_next.hold[i] = pin_keep_in[i] && s_next.pin_oe_n[i];
			end
		end
		if (!s_reg.rst_sync)
		begin
			s_next.mode = bst_pkg::PM_NORMAL;
			s_next.cfg_valid = 1'b0;
			s_next.pin_oe_n = '1;
			s_next.hold = '0;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			s_reg <= '{mode: bst_pkg::PM_NORMAL, pin_oe_n: '1, default: '0};
		else
			s_reg <= s_next;
	end

	// outputs straight from flip-flops
	assign tdo_out = n_reg.tdo;
	assign tdo_oe_n_out = n_reg.tdo_oe_n;
	assign pin_out = s_reg.pin;
	assign pin_oe_n_out = s_reg.pin_oe_n;
	assign pin_hold_out = s_reg.hold;
	assign cfg_data_out = s_reg.cfg_data;
	assign cfg_valid_out = s_reg.cfg_valid;
endmodule // bst_tap_top
`default_nettype wire

// ### bst_tap_top_properties.sv
// Purpose: port-level properties of the test port
// Assumes: tms changes only after a falling tck; core and keeper inputs quiet while checked
// Notes: tap state is inferred from tms and the tdo enable
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"
module bst_tap_props #(
	parameter int BSR_LEN = `BST_BSR_LEN
) (
	// clocks and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic tck_in,
	// test port
	input wire logic tms_in,
	input wire logic tdo_oe_n_out,
	// status and pins
	input wire logic config_busy_in,
	input wire logic cfg_valid_out,
	input wire logic [BSR_LEN/3-1:0] core_out_in,
	input wire logic [BSR_LEN/3-1:0] core_oe_n_in,
	input wire logic [BSR_LEN/3-1:0] pin_keep_in,
	input wire logic [BSR_LEN/3-1:0] pin_out,
	input wire logic [BSR_LEN/3-1:0] pin_oe_n_out,
	input wire logic [BSR_LEN/3-1:0] pin_hold_out
);
	// the enable seen at a fall was launched one fall earlier, so the tms that steered it is one fall back
	a_oe_enter_low: assert property (@(negedge tck_in) disable iff (!arst_n_in)
		$fell(tdo_oe_n_out) |-> !$past(tms_in)) else $error("tdo enabled after tms high");
	a_oe_leave_high: assert property (@(negedge tck_in) disable iff (!arst_n_in)
		$rose(tdo_oe_n_out) |-> $past(tms_in)) else $error("tdo released after tms low");
	a_oe_stay_shift: assert property (@(negedge tck_in) disable iff (!arst_n_in)
		!$past(tdo_oe_n_out) && !$past(tms_in) |-> !tdo_oe_n_out) else $error("tdo dropped in shift");
	a_oe_no_entry: assert property (@(negedge tck_in) disable iff (!arst_n_in)
		$past(tdo_oe_n_out) && $past(tms_in) |-> tdo_oe_n_out) else $error("tdo enabled outside shift");
	// handovers are spaced, so each byte strobe is a lone pulse
	a_cfg_lone_pulse: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		cfg_valid_out |=> !cfg_valid_out [*3]) else $error("config strobe too long");
	// keeper only on floated pins that ask for it
	a_keep_floated: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		(pin_hold_out & (~pin_keep_in | ~pin_oe_n_out)) == '0) else $error("keeper misplaced");
	// busy configuration hands the pins back to the core
	a_busy_data: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		config_busy_in [*6] |-> pin_out == core_out_in) else $error("pins not core during busy");
	a_busy_enable: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		config_busy_in [*6] |-> pin_oe_n_out == core_oe_n_in && pin_hold_out == '0)
		else $error("pin enable not core during busy");
endmodule // bst_tap_props
`default_nettype wire

// ### bst_jtag_host.sv
// Purpose: behavioural test controller driving the test port
// Assumes: one tck period is 80 ns; tck stands low between frames
// Notes: tdi carries the inverse of its last value when not shifting
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_host (
	// test port
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in
);
	logic so;
	// idle levels; tms high keeps the tap in reset
	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
		so = 1'b0;
	end
	// one period; tdo is taken at the rise, where the device takes tms and tdi
	task automatic tick(input logic t, input logic d);
		tms_out = t;
		tdi_out = d;
		#20 tck_out = 1'b1;
		so = tdo_in;
		#40 tck_out = 1'b0;
		#20;
	endtask
	// five ones reach test-logic reset from anywhere, then idle
	task automatic reset_tap;
		repeat (5) tick(1'b1, ~tdi_out);
		tick(1'b0, ~tdi_out);
	endtask
	// idle to shift, n bits lsb first, update and back to idle
	task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
		dout = '0;
		tick(1'b1, ~tdi_out);
		if (ir)
			tick(1'b1, ~tdi_out);
		tick(1'b0, ~tdi_out);
		tick(1'b0, ~tdi_out);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i]);
			dout[i] = so;
		end
		tick(1'b1, ~tdi_out);
		tick(1'b0, ~tdi_out);
	endtask
endmodule // bst_jtag_host
`default_nettype wire

// ### bst_tap_tb_top.sv
// Purpose: self-checking bench of the test port
// Assumes: a six-cell boundary chain, two user pins
// Notes: tck comes from the controller model, out of phase with the system clock
`timescale 1ns/1ps
`default_nettype none
`include "bst_consts.svh"
module bst_tap_tb_top;
	localparam int NB = 6;
	logic clock_in, arst_n_in, tck, tms, tdi, tdo, tdo_oe_n, busy, cfg_valid;
	logic [1:0] core_out, pin_out, pin_oe_n, pin_hold;
	logic [7:0] cfg_data;
	logic [63:0] o;
	int fails = 0;
	int checks = 0;
	bst_jtag_host host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
	bst_tap_top #(.BSR_LEN(NB)) dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .tck_in(tck),
		.tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .config_busy_in(busy),
		.usercode_in(32'h5a3c_9612), .probe_in(32'h8d71_e04b), .core_out_in(core_out),
		.core_oe_n_in(2'h1), .pin_keep_in(2'h2), .pin_in(2'h1), .pin_out(pin_out),
		.pin_oe_n_out(pin_oe_n), .pin_hold_out(pin_hold), .cfg_data_out(cfg_data),
		.cfg_valid_out(cfg_valid));
	// system clock, 40 ns
	initial
	begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// pins settle a few system clocks after each handover
	// ends just after an edge, so pins are read and inputs changed away from the launching edge
	task automatic settle;
		repeat (8) @(posedge clock_in);
		#2;
	endtask
	task automatic t_idcode;
		host.scan(1'b0, 32, '0, o);
		check("idcode", o[31:0], {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1});
		check("id lsb", o[0], 1'b1);
		check("tdo idle", tdo_oe_n, 1'b1);
	endtask
	// twenty bits: capture pattern, then the first ten bits return
	task automatic t_ir;
		host.scan(1'b1, 20, {`BST_I_IDCODE, 10'h2a5}, o);
		check("ir capture", o[9:0], 10'h001);
		check("ir pass", o[19:10], 10'h2a5);
		t_idcode;
	endtask
	task automatic t_bypass;
		logic [9:0] codes [4];
		codes = '{`BST_I_BYPASS, `BST_I_HIGHZ, `BST_I_CLAMP, 10'h155};
		foreach (codes[k])
		begin
			host.scan(1'b1, 10, 64'(codes[k]), o);
			host.scan(1'b0, 8, 64'ha5, o);
			check("bypass", o[7:0], 8'h4a);
		end
	endtask
	task automatic t_regs;
		host.scan(1'b1, 10, `BST_I_USERCODE, o);
		host.scan(1'b0, 32, '0, o);
		check("usercode", o[31:0], 32'h5a3c_9612);
		host.scan(1'b1, 10, `BST_I_ANALYZER, o);
		host.scan(1'b0, 32, '0, o);
		check("probe", o[31:0], 32'h8d71_e04b);
	endtask
	task automatic t_pins;
		host.scan(1'b1, 10, `BST_I_SAMPLE, o);
		host.scan(1'b0, NB, 64'h02, o);
		check("sample cap", {o[3], o[0]}, 2'h1);
		settle;
		check("sample pins", {pin_oe_n, pin_out}, {2'h1, core_out});
		host.scan(1'b1, 10, `BST_I_EXTEST, o);
		settle;
		check("extest out", {pin_oe_n, pin_out}, 4'h1);
		host.scan(1'b0, NB, 64'h02, o);
		check("extest cap", {o[3], o[0]}, 2'h1);
		host.scan(1'b1, 10, `BST_I_CLAMP, o);
		settle;
		check("clamp", {pin_oe_n, pin_out}, 4'h1);
		host.scan(1'b1, 10, `BST_I_HIGHZ, o);
		settle;
		check("highz", {pin_hold, pin_oe_n}, 4'hb);
		core_out = 2'h3;
		host.reset_tap;
		settle;
		check("normal", {pin_oe_n, pin_out}, 4'h7);
	endtask
	// boundary tests are refused while configuration runs
	task automatic t_busy;
		@(posedge clock_in);
		#2 busy = 1'b1;
		host.scan(1'b1, 10, `BST_I_EXTEST, o);
		host.scan(1'b0, 8, 64'ha5, o);
		check("busy bypass", o[7:0], 8'h4a);
		settle;
		check("busy pins", {pin_oe_n, pin_out}, 4'h7);
		@(posedge clock_in);
		#2 busy = 1'b0;
		host.reset_tap;
	endtask
	task automatic t_cfg;
		int n;
		host.scan(1'b1, 10, `BST_I_CFG_LOAD, o);
		host.scan(1'b0, 8, 64'hc3, o);
		n = 0;
		while (cfg_valid !== 1'b1 && n < 20)
		begin
			@(posedge clock_in);
			#1;
			n++;
		end
		check("cfg byte", {cfg_valid, cfg_data}, 9'h1c3);
		if (n == 20)
			tally_and_finish;
	endtask
	// reset spans tck edges, then the scenarios
	initial
	begin
		arst_n_in = 1'b0;
		busy = 1'b0;
		core_out = 2'h2;
		#7;
		repeat (2) host.tick(1'b1, 1'b0);
		repeat (2) @(posedge clock_in);
		#2 arst_n_in = 1'b1;
		settle;
		host.reset_tap;
		t_idcode;
		t_ir;
		t_bypass;
		t_regs;
		t_pins;
		t_busy;
		t_cfg;
		tally_and_finish;
	end
endmodule // bst_tap_tb_top
bind bst_tap_top bst_tap_props #(.BSR_LEN(BSR_LEN)) u_props (.clock_in, .arst_n_in, .tck_in, .tms_in,
	.tdo_oe_n_out, .config_busy_in, .cfg_valid_out, .core_out_in, .core_oe_n_in, .pin_keep_in,
	.pin_out, .pin_oe_n_out, .pin_hold_out);
`default_nettype wire
